// ===== rtl/nv_access_defines.svh
// Offsets, field positions, reset values and timing counts for the nonvolatile byte controller.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef NV_ACCESS_DEFINES_SVH
`define NV_ACCESS_DEFINES_SVH

// Array geometry
`define NV_ADDR_W 6
`define NV_DEPTH 64
`define NV_DATA_W 8

// Control register placement behind the indirect pointer
`define NV_CTRL_BANK 8'h01
`define NV_CTRL_OFFSET 8'h40
`define NV_BANK_RESET 8'h00

// Control register bit positions
`define NV_BIT_RD_TRIG 0
`define NV_BIT_RD_PERMIT 1
`define NV_BIT_WR_TRIG 2
`define NV_BIT_WR_PERMIT 3

// Reset values
`define NV_CTRL_RESET 4'h0
`define NV_BYTE_RESET 8'h00

// Timing: read takes two system cycles, write takes a number of timer ticks
`define NV_READ_CYCLES 2
`define NV_WRITE_TICKS 4

`endif

// ===== rtl/nv_access_pkg.sv
// Types shared by the nonvolatile byte controller and its array.
// Assumes nv_access_defines.svh is on the include path.
`default_nettype none
`include "nv_access_defines.svh"

package nv_access_pkg;
  typedef logic [`NV_ADDR_W-1:0] nv_addr_t;
  typedef logic [`NV_DATA_W-1:0] nv_byte_t;
  // Gray codes along idle -> read -> idle; idle -> write and back flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11
  } nv_state_t;
endpackage : nv_access_pkg

`default_nettype wire

// ===== rtl/nv_array_if.sv
// Carrier between the access controller and the byte array.
// Assumes one system clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface nv_array_if;
  import nv_access_pkg::*;
  logic rd_en;
  logic wr_en;
  nv_addr_t addr;
  nv_byte_t wdata;
  nv_byte_t rdata;
  modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : nv_array_if

`default_nettype wire

// ===== rtl/nv_byte_array.sv
// Nonvolatile byte array model: 64 bytes, registered read data.
// Assumes the controller holds address and data stable around each strobe.
`timescale 1ns/1ns
`default_nettype none
`include "nv_access_defines.svh"

module nv_byte_array #(
  parameter int DEPTH = `NV_DEPTH
) (
  input wire logic clk_sys,
  nv_array_if.mem port_m
);
  import nv_access_pkg::*;

  nv_byte_t cells_q [DEPTH];
  nv_byte_t rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Storage keeps contents across reset, as nonvolatile cells would
  always_ff @(posedge clk_sys) begin
    if (port_m.wr_en) begin
      cells_q[port_m.addr] <= port_m.wdata;
    end
  end

  // Read data comes out of a register one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (port_m.rd_en) begin
      rdata_q <= cells_q[port_m.addr];
    end
  end

  assign port_m.rdata = rdata_q;
endmodule : nv_byte_array

`default_nettype wire

// ===== rtl/eeprom_byte_access_ctrl.sv
// Access controller for the 64-byte nonvolatile data memory.
// Assumes a processor core drives the register strobes synchronously to clk_sys
// and an independent write timer oscillator supplies wr_timer_tick.
//
// What this block does
// - Read trigger starts a byte read only when read permit was already set.
// - Read trigger with read permit clear starts nothing.
// - Read end clears read trigger; fetched byte then sits in data register.
// - Data register holds the read result until another read or write.
// - Write trigger with write permit clear starts no write.
// - Write length counted on the independent timer, so system cycles vary.
// - Write end clears the write trigger bit.
// - Reset clears write permit.
// - Control register reachable only in bank one; bank pointer resets to zero.
// - Write end sets the interrupt flag; read end does not.
// - Vector jump needs flag, global enable, local enable and stack not full.
// - Servicing the interrupt clears its flag automatically.
// - 64 bytes, 6-bit address, two upper address bits read zero.
// - Control register sits at offset 40 of bank one, reached indirectly.
`timescale 1ns/1ns
`default_nettype none
`include "nv_access_defines.svh"

module eeprom_byte_access_ctrl #(
  parameter int WRITE_TICKS = `NV_WRITE_TICKS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic addr_wr_en,
  input wire nv_access_pkg::nv_byte_t addr_wdata,
  input wire logic data_wr_en,
  input wire nv_access_pkg::nv_byte_t data_wdata,
  input wire logic bank_wr_en,
  input wire nv_access_pkg::nv_byte_t bank_wdata,
  input wire nv_access_pkg::nv_byte_t indirect_pointer_one,
  input wire logic indirect_access_one_wr_en,
  input wire nv_access_pkg::nv_byte_t indirect_access_one_wdata,
  input wire logic wr_timer_tick,
  input wire logic global_irq_enable,
  input wire logic nv_irq_enable,
  input wire logic stack_full,
  output logic [7:0] nv_address_reg,
  output logic [7:0] nv_data_reg,
  output logic [7:0] nv_control_reg,
  output logic [7:0] indirect_access_one_rdata,
  output logic [7:0] bank_select_pointer,
  output logic nv_irq_flag,
  output logic irq_vector_req
);
  import nv_access_pkg::*;

  nv_state_t state_q;
  nv_addr_t addr_q;
  nv_byte_t data_q;
  logic rd_trig_q, rd_permit_q, wr_trig_q, wr_permit_q;
  nv_byte_t bank_q;
  nv_byte_t ind_rdata_q;
  logic irq_flag_q, irq_req_q;
  logic tick_q;
  logic [7:0] tick_cnt_q;
  logic rd_phase_q;
  logic ctrl_sel, ctrl_wr, start_wr, start_rd, rd_done, wr_done, tick_rise;

  nv_array_if arr ();

  nv_byte_array #(.DEPTH(`NV_DEPTH)) u_array (
    .clk_sys(clk_sys),
    .port_m(arr)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode and start conditions; permit must already be set before the trigger
  assign ctrl_sel = (bank_q == `NV_CTRL_BANK) && (indirect_pointer_one == `NV_CTRL_OFFSET);
  assign ctrl_wr = indirect_access_one_wr_en && ctrl_sel;
  // Write wins if firmware breaks the one-trigger convention
  assign start_wr = ctrl_wr && (state_q == ST_IDLE) && indirect_access_one_wdata[`NV_BIT_WR_TRIG]
                    && wr_permit_q;
  assign start_rd = ctrl_wr && (state_q == ST_IDLE) && indirect_access_one_wdata[`NV_BIT_RD_TRIG]
                    && rd_permit_q && !start_wr;
  assign tick_rise = wr_timer_tick && !tick_q;
  assign rd_done = (state_q == ST_READ) && rd_phase_q;
  assign wr_done = (state_q == ST_WRITE) && tick_rise && (tick_cnt_q == 8'(WRITE_TICKS - 1));

  // Array strobes use the frozen address and data
  assign arr.rd_en = (state_q == ST_READ) && !rd_phase_q;
  assign arr.wr_en = wr_done;
  assign arr.addr = addr_q;
  assign arr.wdata = data_q;

  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      rd_phase_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          rd_phase_q <= 1'b0;
          if (start_wr) begin
            state_q <= ST_WRITE;
          end else if (start_rd) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          rd_phase_q <= 1'b1;
          if (rd_done) begin
            state_q <= ST_IDLE;
            rd_phase_q <= 1'b0;
          end
        end
        ST_WRITE: begin
          if (wr_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Write timer ticks arrive from a free oscillator; counting them makes duration independent of clk_sys
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_q <= 1'b0;
      tick_cnt_q <= 8'h00;
    end else begin
      tick_q <= wr_timer_tick;
      if (state_q != ST_WRITE) begin
        tick_cnt_q <= 8'h00;
      end else if (tick_rise) begin
        tick_cnt_q <= tick_cnt_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control bits; triggers only accept writes while idle so a busy cycle cannot be disturbed
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {wr_permit_q, wr_trig_q, rd_permit_q, rd_trig_q} <= `NV_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        wr_permit_q <= indirect_access_one_wdata[`NV_BIT_WR_PERMIT];
        rd_permit_q <= indirect_access_one_wdata[`NV_BIT_RD_PERMIT];
      end
      if (start_wr) begin
        wr_trig_q <= 1'b1;
      end else if (wr_done) begin
        wr_trig_q <= 1'b0;
      end
      if (start_rd) begin
        rd_trig_q <= 1'b1;
      end else if (rd_done) begin
        rd_trig_q <= 1'b0;
      end
    end
  end

  // Address and data registers frozen while busy; read result loads data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      addr_q <= '0;
      data_q <= `NV_BYTE_RESET;
    end else begin
      if (addr_wr_en && state_q == ST_IDLE) begin
        addr_q <= addr_wdata[`NV_ADDR_W-1:0];
      end
      if (rd_done) begin
        data_q <= arr.rdata;
      end else if (data_wr_en && state_q == ST_IDLE) begin
        data_q <= data_wdata;
      end
    end
  end

  // Bank pointer starts in bank zero, shielding the control register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bank_q <= `NV_BANK_RESET;
    end else if (bank_wr_en) begin
      bank_q <= bank_wdata;
    end
  end

  // Indirect read port returns the control register only at its slot
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ind_rdata_q <= 8'h00;
    end else begin
      ind_rdata_q <= ctrl_sel ? {4'h0, wr_permit_q, wr_trig_q, rd_permit_q, rd_trig_q} : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-complete interrupt; a new completion beats the service clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_flag_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= irq_flag_q && global_irq_enable && nv_irq_enable && !stack_full && !irq_req_q;
      if (wr_done) begin
        irq_flag_q <= 1'b1;
      end else if (irq_req_q) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  assign nv_address_reg = {2'b00, addr_q};
  assign nv_data_reg = data_q;
  assign nv_control_reg = {4'h0, wr_permit_q, wr_trig_q, rd_permit_q, rd_trig_q};
  assign indirect_access_one_rdata = ind_rdata_q;
  assign bank_select_pointer = bank_q;
  assign nv_irq_flag = irq_flag_q;
  assign irq_vector_req = irq_req_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_read_needs_permit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(rd_trig_q) |-> $past(rd_permit_q)) else $error("read started without permit");
  a_no_read_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctrl_wr && state_q == ST_IDLE && !rd_permit_q && !start_wr) |=> !rd_trig_q)
    else $error("read started with permit clear");
  a_read_two_cycles: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(rd_trig_q) |-> rd_trig_q ##1 rd_trig_q ##1 !rd_trig_q) else $error("read length wrong");
  a_data_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q == ST_IDLE && !data_wr_en) |=> $stable(data_q)) else $error("data register changed");
  a_write_needs_permit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(wr_trig_q) |-> $past(wr_permit_q)) else $error("write started without permit");
  a_write_tick_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(wr_trig_q) |-> $past(tick_cnt_q) == 8'(WRITE_TICKS - 1)) else $error("write ended early");
  a_write_end_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(wr_trig_q) |-> irq_flag_q) else $error("write end without flag");
  a_read_no_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!irq_flag_q && state_q == ST_READ) |=> !irq_flag_q) else $error("read raised flag");
  a_irq_gating: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irq_vector_req |-> $past(global_irq_enable && nv_irq_enable && !stack_full && irq_flag_q))
    else $error("vector request without enables");
  a_irq_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irq_vector_req && !wr_done) |=> !irq_flag_q) else $error("flag not cleared on service");
  a_bank_guard: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (bank_q != `NV_CTRL_BANK) |=> $stable(wr_permit_q)) else $error("control written outside bank");
  a_addr_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q != ST_IDLE) |=> $stable(addr_q)) else $error("address moved while busy");

  c_read_done: cover property (@(posedge clk_sys) disable iff (sys_rst) rd_done);
  c_write_done: cover property (@(posedge clk_sys) disable iff (sys_rst) wr_done);
  c_irq_taken: cover property (@(posedge clk_sys) disable iff (sys_rst) irq_vector_req);
endmodule : eeprom_byte_access_ctrl

`default_nettype wire

// ===== sim/nv_tick_osc.sv
// Free-running write-timer oscillator standing in for the on-chip timer.
// Assumes nothing of the system clock; its period is deliberately unrelated to it.
`timescale 1ns/1ns
`default_nettype none

module nv_tick_osc #(
  parameter int HALF_NS = 52
) (
  output logic tick
);
  // Even half period keeps tick edges off the clk_sys rising edges, so sampling never races
  initial begin
    tick = 1'b0;
    forever begin
      #(HALF_NS) tick = ~tick;
    end
  end
endmodule : nv_tick_osc

`default_nettype wire

// ===== sim/eeprom_byte_access_ctrl_test.sv
// Self-checking bench for the nonvolatile byte controller.
// Assumes the package and defines are compiled first and the tick model is present.
`timescale 1ns/1ns
`default_nettype none

module eeprom_byte_access_ctrl_test;
  import nv_access_pkg::*;
  localparam int TICKS = 2;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] en = 4'h0;
  nv_byte_t wd = 8'h00;
  nv_byte_t ptr = 8'h00;
  logic gie = 1'b0;
  logic lie = 1'b0;
  logic stk_full = 1'b0;
  logic tick;
  logic [7:0] addr_q, data_q, ctrl_q, ind_q, bank_q;
  logic flag, vec;
  int mismatches = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock, partner and device
  always #5 clk_sys = ~clk_sys;

  nv_tick_osc nv_tick_osc_inst (.tick(tick));

  // One shared write bus; the strobe picks the target register
  eeprom_byte_access_ctrl #(.WRITE_TICKS(TICKS)) eeprom_byte_access_ctrl_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .addr_wr_en(en[0]), .addr_wdata(wd),
    .data_wr_en(en[1]), .data_wdata(wd),
    .bank_wr_en(en[2]), .bank_wdata(wd),
    .indirect_pointer_one(ptr),
    .indirect_access_one_wr_en(en[3]), .indirect_access_one_wdata(wd),
    .wr_timer_tick(tick), .global_irq_enable(gie), .nv_irq_enable(lie),
    .stack_full(stk_full), .nv_address_reg(addr_q), .nv_data_reg(data_q),
    .nv_control_reg(ctrl_q), .indirect_access_one_rdata(ind_q),
    .bank_select_pointer(bank_q), .nv_irq_flag(flag), .irq_vector_req(vec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Access and compare tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // Sel 0 address, 1 data, 2 bank, 3 indirect; returns just after the taking edge
  task automatic put(input int sel, input nv_byte_t v);
    @(posedge clk_sys);
    en <= 4'h1 << sel;
    wd <= v;
    @(posedge clk_sys);
    en <= 4'h0;
    #1;
  endtask : put

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  // Bounded poll; a stuck trigger shows up as a mismatch, not a hang
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    while (ctrl_q[b] === 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    chk1(ctrl_q[b], 1'b0);
  endtask : wait_clear

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the roughly 80 cycles the tests need
  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    int n;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    step(1);
    chk8(ctrl_q, 8'h00);
    chk8(bank_q, 8'h00);
    ptr <= 8'h40;
    put(3, 8'h0A);
    chk8(ctrl_q, 8'h00);
    put(2, 8'h01);
    ptr <= 8'h41;
    put(3, 8'h0A);
    chk8(ctrl_q, 8'h00);
    ptr <= 8'h40;
    put(3, 8'h04);
    step(20);
    chk8(ctrl_q, 8'h00);
    chk1(flag, 1'b0);
    // Write: address beyond 6 bits is cut, permit then trigger
    put(0, 8'hFF);
    chk8(addr_q, 8'h3F);
    put(1, 8'hA5);
    gie <= 1'b0;
    put(3, 8'h08);
    step(1);
    chk8(ind_q, 8'h08);
    put(3, 8'h0C);
    chk1(ctrl_q[2], 1'b1);
    gie <= 1'b1;
    // Busy cycle ignores address and data writes; the write needs at least ten cycles
    put(0, 8'h05);
    chk8(addr_q, 8'h3F);
    put(1, 8'h5A);
    chk8(data_q, 8'hA5);
    wait_clear(2);
    chk8(ctrl_q, 8'h08);
    chk1(flag, 1'b1);
    // Interrupt held off by a full stack while both enables are set
    lie <= 1'b1;
    stk_full <= 1'b1;
    gie <= 1'b1;
    step(4);
    chk1(vec, 1'b0);
    chk1(flag, 1'b1);
    stk_full <= 1'b0;
    n = 0;
    while (vec !== 1'b1 && n < 5) begin
      step(1);
      n++;
    end
    chk1(vec, 1'b1);
    step(1);
    chk1(vec, 1'b0);
    chk1(flag, 1'b0);
    gie <= 1'b0;
    // Read back; firmware clears the data register first
    put(1, 8'h00);
    chk8(data_q, 8'h00);
    put(3, 8'h01);
    step(2);
    chk8(ctrl_q, 8'h00);
    put(3, 8'h02);
    put(3, 8'h03);
    chk1(ctrl_q[0], 1'b1);
    step(1);
    chk1(ctrl_q[0], 1'b1);
    step(1);
    chk1(ctrl_q[0], 1'b0);
    chk8(data_q, 8'hA5);
    step(6);
    chk8(data_q, 8'hA5);
    chk1(flag, 1'b0);
    final_report();
  end
endmodule : eeprom_byte_access_ctrl_test

`default_nettype wire
